// File: verilog/ftri_pkg.sv
// Constants, opcodes, register offsets and state codes for the flow and
// table read instruction unit.
// Assumes a single system clock and a 10-bit program ROM word.
package ftri_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int unsigned PC_W   = 11;
  localparam int unsigned PTR_W  = 12;
  localparam int unsigned WORD_W = 10;
  localparam int unsigned NIB_W  = 4;
  localparam int unsigned T0_W   = 12;
  localparam int unsigned BT_W   = 8;
  localparam int unsigned RA_W   = 4;
  localparam int unsigned INC_W  = 9;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [PC_W-1:0]  PC_RST  = 11'h000;
  localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
  localparam logic [T0_W-1:0]  T0_RST  = 12'h000;
  localparam logic [BT_W-1:0]  BT_RST  = 8'h00;

  // ---------------------------------------------------------------------
  // Instruction encodings and field positions
  // ---------------------------------------------------------------------
  localparam logic [9:0] OP_TBL_RD_INC  = 10'h3C1;
  localparam logic [9:0] OP_INT_RET     = 10'h3C2;
  localparam logic [9:0] OP_PTR_JUMP    = 10'h3C3;
  localparam logic [9:0] OP_PC_CAPTURE  = 10'h3C4;
  localparam logic [9:0] OP_INT_UNMASK  = 10'h3C5;
  localparam logic [9:0] OP_PTR_INC     = 10'h3C6;
  localparam logic [9:0] OP_T0_RELOAD   = 10'h3C7;
  localparam logic [9:0] OP_BT_CLEAR    = 10'h3C8;
  localparam logic [6:0] OP_JUMP_HI     = 7'h70;
  localparam logic [6:0] OP_CALL_HI     = 7'h71;
  localparam int unsigned OP_HI_LSB     = 3;
  localparam int unsigned ACC_LSB       = 0;
  localparam int unsigned RO1_LSB       = 4;
  localparam int unsigned RO2_LSB       = 8;

  // ---------------------------------------------------------------------
  // Register port offsets
  // ---------------------------------------------------------------------
  localparam logic [RA_W-1:0] REG_ACC      = 4'h0;
  localparam logic [RA_W-1:0] REG_PAGE     = 4'h1;
  localparam logic [RA_W-1:0] REG_FLAGS    = 4'h2;
  localparam logic [RA_W-1:0] REG_PTR      = 4'h3;
  localparam logic [RA_W-1:0] REG_RO1      = 4'h4;
  localparam logic [RA_W-1:0] REG_RO2      = 4'h5;
  localparam logic [RA_W-1:0] REG_PC       = 4'h6;
  localparam logic [RA_W-1:0] REG_INT_EN   = 4'h7;
  localparam logic [RA_W-1:0] REG_T0_LATCH = 4'h8;
  localparam logic [RA_W-1:0] REG_T0_COUNT = 4'h9;
  localparam logic [RA_W-1:0] REG_BT_COUNT = 4'hA;
  localparam logic [RA_W-1:0] REG_STATE    = 4'hB;

  // ---------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN   = 5'h01,
    ST_WORD2 = 5'h02,
    ST_TABLE = 5'h04,
    ST_PINC  = 5'h08,
    ST_REDIR = 5'h10
  } ftri_state_t;

endpackage

// File: verilog/ftri_timers.sv
// Timer 0 counter with its initial-value latch input, and the base timer.
// Assumes reload and clear requests arrive as one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
module ftri_timers (
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     t0_reload_i,
  input  wire logic [ftri_pkg::T0_W-1:0] t0_latch_i,
  input  wire logic                     bt_clear_i,
  output logic      [ftri_pkg::T0_W-1:0] t0_count_o,
  output logic      [ftri_pkg::BT_W-1:0] bt_count_o
);

  typedef struct packed {
    logic [ftri_pkg::T0_W-1:0] t0;
    logic [ftri_pkg::BT_W-1:0] bt;
  } ftri_tmr_t;

  ftri_tmr_t cur_ff;
  ftri_tmr_t nxt_tmr;

  // ---------------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------------
  // Both counters run freely; the instruction requests override the count.
  always_comb begin
    nxt_tmr    = cur_ff;
    nxt_tmr.t0 = cur_ff.t0 + 12'h001;
    nxt_tmr.bt = cur_ff.bt + 8'h01;
    if (t0_reload_i) begin
      nxt_tmr.t0 = t0_latch_i;
    end
    if (bt_clear_i) begin
      nxt_tmr.bt = ftri_pkg::BT_RST;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur_ff.t0 <= ftri_pkg::T0_RST;
      cur_ff.bt <= ftri_pkg::BT_RST;
    end else begin
      cur_ff <= nxt_tmr;
    end
  end

  assign t0_count_o = cur_ff.t0;
  assign bt_count_o = cur_ff.bt;

endmodule
`default_nettype wire

// File: verilog/ftri_core.sv
// Execution unit for table reads, jumps, calls, interrupt return, pointer
// handling, interrupt unmask and timer reload/clear instructions.
// Assumes a program ROM that returns the addressed word one cycle after the
// fetch request, and an interrupt stack that presents the saved context.
`timescale 1ns/1ps
`default_nettype none
module ftri_core (
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  output logic      [ftri_pkg::PC_W-1:0]   rom_addr_o,
  output logic                            rom_rd_o,
  input  wire logic [ftri_pkg::WORD_W-1:0] rom_data_i,
  input  wire logic [ftri_pkg::PC_W-1:0]   stk_pc_i,
  input  wire logic [ftri_pkg::NIB_W-1:0]  stk_acc_i,
  input  wire logic [ftri_pkg::NIB_W-1:0]  stk_page_i,
  input  wire logic                       stk_carry_i,
  input  wire logic                       stk_zero_i,
  input  wire logic [ftri_pkg::RA_W-1:0]   reg_addr_i,
  input  wire logic [ftri_pkg::PTR_W-1:0]  reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [ftri_pkg::PTR_W-1:0]  reg_rdata_o,
  output logic                            int_enable_o
);

  typedef struct packed {
    ftri_pkg::ftri_state_t           state;
    logic                            valid;
    logic [ftri_pkg::WORD_W-1:0]     ir;
    logic [ftri_pkg::PC_W-1:0]       pc;
    logic [ftri_pkg::PC_W-1:0]       tgt;
    logic [ftri_pkg::PTR_W-1:0]      ptr;
    logic [ftri_pkg::NIB_W-1:0]      acc;
    logic [ftri_pkg::NIB_W-1:0]      ro1;
    logic [1:0]                      ro2;
    logic [ftri_pkg::NIB_W-1:0]      page;
    logic                            carry;
    logic                            zero;
    logic                            int_en;
    logic [ftri_pkg::T0_W-1:0]       t0_latch;
    logic [ftri_pkg::PTR_W-1:0]      rdata;
  } ftri_core_t;

  ftri_core_t                   cur_ff;
  ftri_core_t                   nxt_core;
  logic                         run_valid;
  logic                         t0_reload;
  logic                         bt_clear;
  logic [ftri_pkg::PC_W-1:0]    fetch_addr;
  logic                         fetch_en;
  logic [ftri_pkg::PC_W-1:0]    word2_tgt;
  logic [ftri_pkg::T0_W-1:0]    t0_count;
  logic [ftri_pkg::BT_W-1:0]    bt_count;
  logic [ftri_pkg::INC_W-1:0]   ptr_lo;

  // rom_data_i holds an instruction only in the run state after a fetch.
  assign run_valid = (cur_ff.state == ftri_pkg::ST_RUN) && cur_ff.valid;
  assign ptr_lo    = cur_ff.ptr[ftri_pkg::INC_W-1:0];

  // ---------------------------------------------------------------------
  // Sequencer and register port
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_core       = cur_ff;
    nxt_core.valid = 1'b0;
    nxt_core.rdata = '0;
    fetch_en       = 1'b0;
    fetch_addr     = cur_ff.pc;
    t0_reload      = 1'b0;
    bt_clear       = 1'b0;
    word2_tgt      = {cur_ff.ir[2:0], rom_data_i[7:0]};

    // Software writes land first so that an instruction in the same cycle wins.
    if (reg_wr_i) begin
      case (reg_addr_i)
        ftri_pkg::REG_ACC:      nxt_core.acc      = reg_wdata_i[3:0];
        ftri_pkg::REG_PAGE:     nxt_core.page     = reg_wdata_i[3:0];
        ftri_pkg::REG_FLAGS:    {nxt_core.zero, nxt_core.carry} = reg_wdata_i[1:0];
        ftri_pkg::REG_PTR:      nxt_core.ptr      = reg_wdata_i;
        ftri_pkg::REG_RO1:      nxt_core.ro1      = reg_wdata_i[3:0];
        ftri_pkg::REG_RO2:      nxt_core.ro2      = reg_wdata_i[1:0];
        ftri_pkg::REG_INT_EN:   nxt_core.int_en   = reg_wdata_i[0];
        ftri_pkg::REG_T0_LATCH: nxt_core.t0_latch = reg_wdata_i;
        default: ;
      endcase
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        ftri_pkg::REG_ACC:      nxt_core.rdata = {8'h00, cur_ff.acc};
        ftri_pkg::REG_PAGE:     nxt_core.rdata = {8'h00, cur_ff.page};
        ftri_pkg::REG_FLAGS:    nxt_core.rdata = {10'h000, cur_ff.zero, cur_ff.carry};
        ftri_pkg::REG_PTR:      nxt_core.rdata = cur_ff.ptr;
        ftri_pkg::REG_RO1:      nxt_core.rdata = {8'h00, cur_ff.ro1};
        ftri_pkg::REG_RO2:      nxt_core.rdata = {10'h000, cur_ff.ro2};
        ftri_pkg::REG_PC:       nxt_core.rdata = {1'b0, cur_ff.pc};
        ftri_pkg::REG_INT_EN:   nxt_core.rdata = {11'h000, cur_ff.int_en};
        ftri_pkg::REG_T0_LATCH: nxt_core.rdata = cur_ff.t0_latch;
        ftri_pkg::REG_T0_COUNT: nxt_core.rdata = t0_count;
        ftri_pkg::REG_BT_COUNT: nxt_core.rdata = {4'h0, bt_count};
        ftri_pkg::REG_STATE:    nxt_core.rdata = {7'h00, cur_ff.state};
        default:                nxt_core.rdata = '0;
      endcase
    end

    unique case (cur_ff.state)
      ftri_pkg::ST_RUN: begin
        if (run_valid && rom_data_i == ftri_pkg::OP_TBL_RD_INC) begin
          // The sequential fetch is held; the ROM port reads the table word.
          fetch_en       = 1'b1;
          fetch_addr     = cur_ff.ptr[ftri_pkg::PC_W-1:0];
          nxt_core.state = ftri_pkg::ST_TABLE;
        end else if (run_valid && (rom_data_i[9:ftri_pkg::OP_HI_LSB] == ftri_pkg::OP_JUMP_HI ||
                                   rom_data_i[9:ftri_pkg::OP_HI_LSB] == ftri_pkg::OP_CALL_HI ||
                                   rom_data_i == ftri_pkg::OP_INT_RET)) begin
          // Fetch the operand word; it is not executed as an instruction.
          fetch_en       = 1'b1;
          nxt_core.pc    = cur_ff.pc + 11'h001;
          nxt_core.ir    = rom_data_i;
          nxt_core.state = ftri_pkg::ST_WORD2;
        end else if (run_valid && rom_data_i == ftri_pkg::OP_PTR_JUMP) begin
          nxt_core.tgt   = cur_ff.ptr[ftri_pkg::PC_W-1:0];
          nxt_core.state = ftri_pkg::ST_REDIR;
        end else if (run_valid && rom_data_i == ftri_pkg::OP_PC_CAPTURE) begin
          // The fetch counter already points one past this instruction.
          nxt_core.ptr   = {1'b0, cur_ff.pc};
          nxt_core.tgt   = cur_ff.pc;
          nxt_core.state = ftri_pkg::ST_REDIR;
        end else if (run_valid && rom_data_i == ftri_pkg::OP_PTR_INC) begin
          nxt_core.state = ftri_pkg::ST_PINC;
        end else begin
          fetch_en       = 1'b1;
          nxt_core.pc    = cur_ff.pc + 11'h001;
          nxt_core.valid = 1'b1;
          if (run_valid && rom_data_i == ftri_pkg::OP_INT_UNMASK) begin
            nxt_core.int_en = 1'b1;
          end
          if (run_valid && rom_data_i == ftri_pkg::OP_T0_RELOAD) begin
            t0_reload = 1'b1;
          end
          if (run_valid && rom_data_i == ftri_pkg::OP_BT_CLEAR) begin
            bt_clear = 1'b1;
          end
        end
      end
      ftri_pkg::ST_WORD2: begin
        if (cur_ff.ir == ftri_pkg::OP_INT_RET) begin
          word2_tgt      = stk_pc_i;
          nxt_core.acc   = stk_acc_i;
          nxt_core.page  = stk_page_i;
          nxt_core.carry = stk_carry_i;
          nxt_core.zero  = stk_zero_i;
        end else if (cur_ff.ir[9:ftri_pkg::OP_HI_LSB] == ftri_pkg::OP_CALL_HI) begin
          nxt_core.ptr = {1'b0, cur_ff.pc};
        end
        fetch_en       = 1'b1;
        fetch_addr     = word2_tgt;
        nxt_core.pc    = word2_tgt + 11'h001;
        nxt_core.valid = 1'b1;
        nxt_core.state = ftri_pkg::ST_RUN;
      end
      ftri_pkg::ST_TABLE: begin
        nxt_core.acc   = rom_data_i[ftri_pkg::ACC_LSB +: 4];
        nxt_core.ro1   = rom_data_i[ftri_pkg::RO1_LSB +: 4];
        nxt_core.ro2   = rom_data_i[ftri_pkg::RO2_LSB +: 2];
        nxt_core.ptr   = cur_ff.ptr + 12'h001;
        nxt_core.tgt   = cur_ff.pc;
        nxt_core.state = ftri_pkg::ST_REDIR;
      end
      ftri_pkg::ST_PINC: begin
        // Only the low nine bits carry; the top bits of the high nibble stay.
        nxt_core.ptr   = {cur_ff.ptr[11:9], ptr_lo + 9'h001};
        nxt_core.tgt   = cur_ff.pc;
        nxt_core.state = ftri_pkg::ST_REDIR;
      end
      ftri_pkg::ST_REDIR: begin
        fetch_en       = 1'b1;
        fetch_addr     = cur_ff.tgt;
        nxt_core.pc    = cur_ff.tgt + 11'h001;
        nxt_core.valid = 1'b1;
        nxt_core.state = ftri_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur_ff <= '{state: ftri_pkg::ST_RUN, pc: ftri_pkg::PC_RST, tgt: ftri_pkg::PC_RST,
                  ptr: ftri_pkg::PTR_RST, t0_latch: ftri_pkg::T0_RST, default: '0};
    end else begin
      cur_ff <= nxt_core;
    end
  end

  assign rom_addr_o   = fetch_addr;
  assign rom_rd_o     = fetch_en;
  assign reg_rdata_o  = cur_ff.rdata;
  assign int_enable_o = cur_ff.int_en;

  // ---------------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------------
  ftri_timers u_timers (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .t0_reload_i (t0_reload),
    .t0_latch_i  (cur_ff.t0_latch),
    .bt_clear_i  (bt_clear),
    .t0_count_o  (t0_count),
    .bt_count_o  (bt_count)
  );

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_table_read_seq: assert property (
    (run_valid && rom_data_i == ftri_pkg::OP_TBL_RD_INC) |-> rom_rd_o ##1
    (cur_ff.state == ftri_pkg::ST_TABLE) ##1 (cur_ff.state == ftri_pkg::ST_REDIR) ##1 run_valid)
    else $error("table read did not take three cycles");

  a_table_load_ptr: assert property (
    (cur_ff.state == ftri_pkg::ST_TABLE) |=> (cur_ff.acc == $past(rom_data_i[3:0]) &&
    cur_ff.ro1 == $past(rom_data_i[7:4]) &&
    cur_ff.ro2 == $past(rom_data_i[9:8]) && cur_ff.ptr == $past(cur_ff.ptr) + 12'h001))
    else $error("table word or pointer advance wrong");

  a_jump_target: assert property (
    (cur_ff.state == ftri_pkg::ST_WORD2 && cur_ff.ir[9:3] == ftri_pkg::OP_JUMP_HI) |->
    rom_rd_o && rom_addr_o == {cur_ff.ir[2:0], rom_data_i[7:0]} ##1 run_valid)
    else $error("direct jump target wrong");

  a_call_link: assert property (
    (run_valid && rom_data_i[9:3] == ftri_pkg::OP_CALL_HI) |=> ##1
    cur_ff.ptr == {1'b0, $past(cur_ff.pc, 2) + 11'h001})
    else $error("call did not save return address");

  a_interrupt_return_target: assert property (
    (cur_ff.state == ftri_pkg::ST_WORD2 && cur_ff.ir == ftri_pkg::OP_INT_RET) |->
    rom_rd_o && rom_addr_o == stk_pc_i)
    else $error("interrupt return target wrong");

  a_interrupt_return_restore: assert property (
    (cur_ff.state == ftri_pkg::ST_WORD2 && cur_ff.ir == ftri_pkg::OP_INT_RET) |=>
    cur_ff.acc == $past(stk_acc_i) && cur_ff.page == $past(stk_page_i) &&
    cur_ff.carry == $past(stk_carry_i) && cur_ff.zero == $past(stk_zero_i))
    else $error("context not restored");

  a_ptr_jump: assert property (
    (run_valid && rom_data_i == ftri_pkg::OP_PTR_JUMP) |-> !rom_rd_o ##1
    (rom_rd_o && rom_addr_o == $past(cur_ff.ptr[10:0])))
    else $error("indirect jump wrong");

  a_pc_capture: assert property (
    (run_valid && rom_data_i == ftri_pkg::OP_PC_CAPTURE) |=>
    cur_ff.ptr == {1'b0, $past(cur_ff.pc)} && rom_rd_o && rom_addr_o == $past(cur_ff.pc))
    else $error("pc capture wrong");

  a_unmask_enable: assert property (
    (run_valid && rom_data_i == ftri_pkg::OP_INT_UNMASK) |-> rom_rd_o ##1 int_enable_o)
    else $error("unmask did not enable");

  // The redirect cycle that closes the increment already fetches again.
  a_ptr_pointer_increment: assert property (
    (run_valid && rom_data_i == ftri_pkg::OP_PTR_INC) |=> !rom_rd_o ##1
    (ptr_lo == $past(ptr_lo, 2) + 9'h001 && rom_rd_o &&
    cur_ff.ptr[11:9] == $past(cur_ff.ptr[11:9], 2)))
    else $error("pointer increment wrong");

  a_t0_reload: assert property (
    (run_valid && rom_data_i == ftri_pkg::OP_T0_RELOAD) |=> t0_count == $past(cur_ff.t0_latch))
    else $error("timer 0 not reloaded");

  a_bt_clear: assert property (
    (run_valid && rom_data_i == ftri_pkg::OP_BT_CLEAR) |=> bt_count == 8'h00)
    else $error("base timer not cleared");

  a_fetch_hold: assert property (
    (cur_ff.state == ftri_pkg::ST_TABLE || cur_ff.state == ftri_pkg::ST_PINC) |->
    !rom_rd_o && !cur_ff.valid)
    else $error("fetch not held");

  c_table_read: cover property (run_valid && rom_data_i == ftri_pkg::OP_TBL_RD_INC);
  c_call: cover property (run_valid && rom_data_i[9:3] == ftri_pkg::OP_CALL_HI);
  c_interrupt_return: cover property (cur_ff.state == ftri_pkg::ST_WORD2 &&
                          cur_ff.ir == ftri_pkg::OP_INT_RET);

endmodule
`default_nettype wire

// File: tb/ftri_rom_model.sv
// Behavioural program ROM that sits on the fetch side of the flow unit.
// Assumes the bench fills mem before reset is released; latency is one cycle.
`timescale 1ns/1ps
`default_nettype none
module ftri_rom_model (
  input  wire logic                        clk_i,
  input  wire logic                        rom_rd_i,
  input  wire logic [ftri_pkg::PC_W-1:0]   rom_addr_i,
  output logic      [ftri_pkg::WORD_W-1:0] rom_data_o
);
  logic [ftri_pkg::WORD_W-1:0] mem [2048];

  // ---------------------------------------------------------------------
  // Fetch port
  // ---------------------------------------------------------------------
  // Without a fetch the word lines toggle, so a stale word is never
  // mistaken for a fresh one.
  always_ff @(posedge clk_i) begin
    if (rom_rd_i) begin
      rom_data_o <= mem[rom_addr_i];
    end else begin
      rom_data_o <= ~rom_data_o;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the flow and table read unit with a ROM model.
// Assumes ftri_core is the top; a pointer jump at word 0 serves as dispatcher.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [10:0] HALT_A = 11'h7F0;
  logic                          clk_i = 1'b0;
  logic                          reset_n_i = 1'b0;
  logic [ftri_pkg::PC_W-1:0]     rom_addr;
  logic [ftri_pkg::WORD_W-1:0]   rom_data;
  logic                          rom_rd;
  logic [ftri_pkg::PC_W-1:0]     stk_pc = 11'h4FF;
  logic [ftri_pkg::NIB_W-1:0]    stk_acc = 4'h9;
  logic [ftri_pkg::NIB_W-1:0]    stk_page = 4'h6;
  logic                          stk_carry = 1'b0;
  logic                          stk_zero = 1'b1;
  logic [ftri_pkg::RA_W-1:0]     reg_addr = 4'h0;
  logic [ftri_pkg::PTR_W-1:0]    reg_wdata = 12'h000;
  logic                          reg_wr = 1'b0;
  logic                          reg_rd = 1'b0;
  logic [ftri_pkg::PTR_W-1:0]    reg_rdata;
  logic                          int_en;
  logic [11:0]                   t0v;
  logic [11:0]                   btv;
  int                            fail_count = 0;
  int                            checks_done = 0;

  always #25 clk_i = ~clk_i;

  ftri_core uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .rom_addr_o(rom_addr),
    .rom_rd_o(rom_rd), .rom_data_i(rom_data), .stk_pc_i(stk_pc), .stk_acc_i(stk_acc),
    .stk_page_i(stk_page), .stk_carry_i(stk_carry), .stk_zero_i(stk_zero),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .int_enable_o(int_en));

  ftri_rom_model rom (.clk_i(clk_i), .rom_rd_i(rom_rd), .rom_addr_i(rom_addr),
    .rom_data_o(rom_data));

  // ---------------------------------------------------------------------
  // Access and compare tasks
  // ---------------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge clk_i);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [11:0] v);
    @(posedge clk_i);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    @(negedge clk_i);
    v = reg_rdata;
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [11:0] exp);
    logic [11:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask

  task automatic put_jmp(input logic [10:0] at, input logic [6:0] op, input logic [10:0] t);
    rom.mem[at] = {op, t[10:8]};
    rom.mem[at + 11'h001] = {2'b00, t[7:0]};
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask

  // Writing the pointer releases the dispatcher loop at word 0; the test
  // code then ends in the self-jump at HALT_A.
  task automatic run_from(input logic [11:0] t);
    int n;
    n = 0;
    wr(ftri_pkg::REG_PTR, t);
    while (n < 300 && !(rom_rd === 1'b1 && rom_addr === HALT_A)) begin
      @(negedge clk_i);
      n++;
    end
    chk("halt loop reached", 12'h001, {11'h000, n < 300});
    repeat (4) @(posedge clk_i);
  endtask

  // ---------------------------------------------------------------------
  // Program image and test sequence
  // ---------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 2048; i++) rom.mem[i] = 10'h000;
    rom.mem[0] = ftri_pkg::OP_PTR_JUMP;
    put_jmp(HALT_A, ftri_pkg::OP_JUMP_HI, HALT_A);
    rom.mem[HALT_A + 11'h002] = ftri_pkg::OP_PTR_INC;
    put_jmp(11'h100, ftri_pkg::OP_CALL_HI, 11'h200);
    rom.mem[11'h102] = 10'h2A5;
    rom.mem[11'h103] = 10'h15B;
    rom.mem[11'h200] = ftri_pkg::OP_TBL_RD_INC;
    rom.mem[11'h201] = ftri_pkg::OP_TBL_RD_INC;
    rom.mem[11'h202] = ftri_pkg::OP_PTR_INC;
    put_jmp(11'h203, ftri_pkg::OP_JUMP_HI, HALT_A);
    rom.mem[11'h3FF] = ftri_pkg::OP_PTR_INC;
    put_jmp(11'h400, ftri_pkg::OP_JUMP_HI, HALT_A);
    rom.mem[11'h300] = ftri_pkg::OP_PC_CAPTURE;
    put_jmp(11'h301, ftri_pkg::OP_JUMP_HI, HALT_A);
    rom.mem[11'h303] = ftri_pkg::OP_TBL_RD_INC;
    rom.mem[11'h600] = ftri_pkg::OP_INT_UNMASK;
    rom.mem[11'h601] = ftri_pkg::OP_T0_RELOAD;
    rom.mem[11'h602] = ftri_pkg::OP_BT_CLEAR;
    rom.mem[11'h603] = ftri_pkg::OP_INT_RET;
    rom.mem[11'h605] = ftri_pkg::OP_PTR_INC;
    put_jmp(11'h4FF, ftri_pkg::OP_JUMP_HI, HALT_A);

    do_reset();
    run_from(12'h100);
    rd_chk("accumulator", ftri_pkg::REG_ACC, 12'h00B);
    rd_chk("readout one", ftri_pkg::REG_RO1, 12'h005);
    rd_chk("readout two", ftri_pkg::REG_RO2, 12'h001);
    rd_chk("pointer after call", ftri_pkg::REG_PTR, 12'h105);
    rd_chk("unmapped read", 4'hF, 12'h000);
    rd_chk("readout two again", ftri_pkg::REG_RO2, 12'h001);
    @(negedge clk_i);
    chk("read data idle", 12'h000, reg_rdata);

    do_reset();
    run_from(12'h3FF);
    rd_chk("pointer carry", ftri_pkg::REG_PTR, 12'h200);

    do_reset();
    run_from(12'h300);
    rd_chk("captured pc", ftri_pkg::REG_PTR, 12'h301);
    rd_chk("no stray table read", ftri_pkg::REG_ACC, 12'h000);

    do_reset();
    chk("entrance after reset", 12'h000, {11'h000, int_en});
    wr(ftri_pkg::REG_T0_LATCH, 12'h321);
    // Opposite flag values beforehand, so a missed restore of either flag shows.
    wr(ftri_pkg::REG_FLAGS, 12'h001);
    rd_chk("flags written", ftri_pkg::REG_FLAGS, 12'h001);
    run_from(12'h600);
    chk("entrance enabled", 12'h001, {11'h000, int_en});
    rd_chk("enable register", ftri_pkg::REG_INT_EN, 12'h001);
    rd_chk("restored acc", ftri_pkg::REG_ACC, 12'h009);
    rd_chk("restored page", ftri_pkg::REG_PAGE, 12'h006);
    rd_chk("restored flags", ftri_pkg::REG_FLAGS, 12'h002);
    rd_chk("pointer untouched", ftri_pkg::REG_PTR, 12'h600);
    rd(ftri_pkg::REG_T0_COUNT, t0v);
    rd(ftri_pkg::REG_BT_COUNT, btv);
    chk("timer0 near latch", 12'h001, {11'h000, t0v >= 12'h321 && t0v < 12'h360});
    chk("base timer since clear", t0v - 12'h320, btv);
    wr(ftri_pkg::REG_INT_EN, 12'h000);
    @(negedge clk_i);
    chk("entrance cleared by software", 12'h000, {11'h000, int_en});
    test_done();
  end

  initial begin
    #1000000;
    fail_count++;
    $display("mismatch watchdog expected finish seen timeout");
    test_done();
  end
endmodule
`default_nettype wire
